// file: rx_status_word.sv
// receive status word builder, receiver stop/start and receiver error flag
`timescale 1ns/1ps
`default_nettype none
`include "rx_consts.svh"

module rx_status_word #(
  parameter int STS_DEPTH = 16
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // mii receive nibble stream
  input  wire logic        i_mii_valid,
  input  wire logic        i_mii_dv,
  input  wire logic        i_mii_er,
  input  wire logic [3:0]  i_mii_d,
  input  wire logic        i_mii_col,
  // 10 mbps mode and trailing bit count
  input  wire logic        i_mode_10,
  input  wire logic [2:0]  i_tail_bits,
  // mac control register bits
  input  wire logic        i_receive_enable_bit,
  input  wire logic        i_pass_bad_frames,
  // host side of the status fifo
  input  wire logic        i_sts_rd,
  input  wire logic        i_sts_flush,
  output logic      [31:0] o_sts_data,
  output logic             o_sts_valid,
  output logic             o_sts_empty,
  output logic             o_sts_full,
  // data fifo underrun and error flag
  input  wire logic        i_data_underrun,
  input  wire logic        i_rxe_clr,
  output logic             o_receiver_error_flag,
  // receiver state
  output logic             o_receiver_halted_irq,
  output logic             o_rx_halted
);

  localparam int AW = $clog2(STS_DEPTH);
  // ****************************************************************
  // registers
  // ****************************************************************
  rx_pkg::rx_state_t state_q;
  rx_pkg::rx_state_t state_d;
  logic [14:0]       nib_cnt_q;
  logic [3:0]        lo_nib_q;
  logic [31:0]       crc_q;
  logic [15:0]       type_q;
  logic              mcast_q;
  logic              bcast_q;
  logic              late_col_q;
  logic              mii_err_q;
  logic              halt_pulse_q;
  logic              rxe_q;
  logic              sts_valid_q;
  logic [AW:0]       wr_ptr_q;
  logic [AW:0]       rd_ptr_q;

  // ****************************************************************
  // decode of the nibble stream
  // ****************************************************************
  wire        data_nib   = (state_q == rx_pkg::RX_DATA) && i_mii_valid && i_mii_dv;
  wire        frame_done = (state_q == rx_pkg::RX_DATA) && i_mii_valid && !i_mii_dv;
  wire        sfd_seen   = (state_q == rx_pkg::RX_PREAMBLE) && i_mii_valid && i_mii_dv
                           && (i_mii_d == `RX_SFD_NIB);
  wire [13:0] byte_cnt   = nib_cnt_q[14:1];
  wire        byte_done  = data_nib && nib_cnt_q[0];
  wire [7:0]  cur_byte   = {i_mii_d, lo_nib_q};
  wire        nib_sat    = &nib_cnt_q;

  function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `RX_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ****************************************************************
  // receiver state machine
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rx_pkg::RX_HALTED: begin
        if (i_receive_enable_bit) begin
          state_d = rx_pkg::RX_IDLE;
        end
      end
      rx_pkg::RX_IDLE: begin
        if (!i_receive_enable_bit) begin
          state_d = rx_pkg::RX_HALTED;
        end else if (i_mii_valid && i_mii_dv) begin
          state_d = rx_pkg::RX_PREAMBLE;
        end
      end
      rx_pkg::RX_PREAMBLE: begin
        if (!i_receive_enable_bit) begin
          state_d = rx_pkg::RX_HALTED;
        end else if (i_mii_valid && !i_mii_dv) begin
          state_d = rx_pkg::RX_IDLE;
        end else if (sfd_seen) begin
          state_d = rx_pkg::RX_DATA;
        end
      end
      rx_pkg::RX_DATA: begin
        if (frame_done) begin
          state_d = rx_pkg::RX_IDLE;
        end
      end
    endcase
  end

  wire enter_halt = (state_q != rx_pkg::RX_HALTED) && (state_d == rx_pkg::RX_HALTED);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q      <= rx_pkg::RX_HALTED;
      halt_pulse_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      halt_pulse_q <= enter_halt;
    end
  end

  // ****************************************************************
  // frame accumulation
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      nib_cnt_q  <= '0;
      lo_nib_q   <= '0;
      crc_q      <= `RX_CRC_INIT;
      type_q     <= '0;
      mcast_q    <= 1'b0;
      bcast_q    <= 1'b0;
      late_col_q <= 1'b0;
      mii_err_q  <= 1'b0;
    end else if (sfd_seen) begin
      nib_cnt_q  <= '0;
      crc_q      <= `RX_CRC_INIT;
      type_q     <= '0;
      mcast_q    <= 1'b0;
      bcast_q    <= 1'b1;
      late_col_q <= 1'b0;
      mii_err_q  <= 1'b0;
    end else if (data_nib) begin
      if (!nib_sat) begin
        nib_cnt_q <= nib_cnt_q + 15'h1;
      end
      lo_nib_q <= i_mii_d;
      if (byte_done) begin
        crc_q <= crc_nib(crc_nib(crc_q, lo_nib_q), i_mii_d);
      end
      if (i_mii_er) begin
        mii_err_q <= 1'b1;
      end
      if (i_mii_col && byte_cnt >= `RX_RUNT_BYTES) begin
        late_col_q <= 1'b1;
      end
      if (byte_done && byte_cnt == 14'h0) begin
        mcast_q <= cur_byte[0];
      end
      if (byte_done && byte_cnt < `RX_DA_BYTES && cur_byte != 8'hff) begin
        bcast_q <= 1'b0;
      end
      if (byte_done && byte_cnt == `RX_TYPE_HI_IDX) begin
        type_q[15:8] <= cur_byte;
      end
      if (byte_done && byte_cnt == `RX_TYPE_LO_IDX) begin
        type_q[7:0] <= cur_byte;
      end
    end
  end

  // ****************************************************************
  // status word assembly
  // ****************************************************************
  wire f_runt     = byte_cnt < `RX_RUNT_BYTES;
  wire f_too_long = byte_cnt > `RX_MAX_BYTES;
  wire f_ftype    = (byte_cnt >= `RX_HDR_BYTES) && (type_q > `RX_TYPE_MIN);
  wire f_wdog     = byte_cnt > `RX_WDOG_BYTES;
  wire f_crc_err  = (crc_q != `RX_CRC_RESIDUE) || mii_err_q;
  wire drib_raw   = i_mode_10 ? (i_tail_bits >= `RX_DRIB_10_MIN) : nib_cnt_q[0];
  wire f_dribble  = drib_raw && !late_col_q;
  wire f_err_sum  = f_runt || f_too_long || late_col_q || f_crc_err;

  logic [31:0] sts_word;
  always_comb begin
    sts_word                             = '0;
    sts_word[`ST_LEN_MSB:`ST_LEN_LSB]    = byte_cnt;
    sts_word[`ST_ERR_SUM]                = f_err_sum;
    sts_word[`ST_BCAST]                  = bcast_q;
    sts_word[`ST_RUNT]                   = f_runt;
    sts_word[`ST_MCAST]                  = mcast_q;
    sts_word[`ST_TOO_LONG]               = f_too_long;
    sts_word[`ST_LATE_COL]               = late_col_q;
    sts_word[`ST_FTYPE]                  = f_ftype;
    sts_word[`ST_WDOG]                   = f_wdog;
    sts_word[`ST_MII_ERR]                = mii_err_q;
    sts_word[`ST_DRIBBLE]                = f_dribble;
    sts_word[`ST_CRC_ERR]                = f_crc_err;
  end

  // ****************************************************************
  // status fifo
  // ****************************************************************
  wire sts_empty = (wr_ptr_q == rd_ptr_q);
  wire sts_full  = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) && (wr_ptr_q[AW] != rd_ptr_q[AW]);
  wire forward   = frame_done && (!f_runt || i_pass_bad_frames);
  wire sts_wr    = forward && !sts_full;
  wire sts_rd    = i_sts_rd && !sts_empty;
  wire overrun   = forward && sts_full;
  wire underrun  = (i_sts_rd && sts_empty) || i_data_underrun;
  wire flush     = i_sts_flush && (state_q == rx_pkg::RX_HALTED);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      sts_valid_q <= 1'b0;
    end else if (flush) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      sts_valid_q <= 1'b0;
    end else begin
      if (sts_wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (sts_rd) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      sts_valid_q <= sts_rd;
    end
  end

  rx_status_mem #(
    .WIDTH (32),
    .DEPTH (STS_DEPTH),
    .AW    (AW)
  ) u_mem (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_wr_en   (sts_wr),
    .i_wr_addr (wr_ptr_q[AW-1:0]),
    .i_wr_data (sts_word),
    .i_rd_en   (sts_rd),
    .i_rd_addr (rd_ptr_q[AW-1:0]),
    .o_rd_data (o_sts_data)
  );

  // ****************************************************************
  // receiver error flag
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rxe_q <= 1'b0;
    end else if (overrun || underrun) begin
      rxe_q <= 1'b1;
    end else if (i_rxe_clr) begin
      rxe_q <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_sts_valid           = sts_valid_q;
  assign o_sts_empty           = sts_empty;
  assign o_sts_full            = sts_full;
  assign o_receiver_error_flag = rxe_q;
  assign o_receiver_halted_irq = halt_pulse_q;
  assign o_rx_halted           = (state_q == rx_pkg::RX_HALTED);

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_runt;
    @(posedge i_clk) disable iff (!i_nrst)
    sts_wr |-> (sts_word[`ST_RUNT] == (sts_word[`ST_LEN_MSB:`ST_LEN_LSB] < 14'd64));
  endproperty
  a_runt: assert property (p_runt) else $error("runt flag wrong");
  property p_runt_drop;
    @(posedge i_clk) disable iff (!i_nrst)
    (frame_done && f_runt && !i_pass_bad_frames) |=> (wr_ptr_q == $past(wr_ptr_q));
  endproperty
  a_runt_drop: assert property (p_runt_drop) else $error("runt forwarded");
  property p_reserved;
    @(posedge i_clk) disable iff (!i_nrst)
    sts_wr |-> (sts_word[9:8] == 2'h0 && sts_word[0] == 1'b0 && sts_word[31:30] == 2'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_too_long;
    @(posedge i_clk) disable iff (!i_nrst)
    sts_wr |-> (sts_word[`ST_TOO_LONG] == (sts_word[`ST_LEN_MSB:`ST_LEN_LSB] > 14'd1518));
  endproperty
  a_too_long: assert property (p_too_long) else $error("too long flag wrong");
  property p_drib_col;
    @(posedge i_clk) disable iff (!i_nrst)
    (sts_wr && sts_word[`ST_LATE_COL]) |-> !sts_word[`ST_DRIBBLE];
  endproperty
  a_drib_col: assert property (p_drib_col) else $error("dribble with collision");
  property p_mii_crc;
    @(posedge i_clk) disable iff (!i_nrst)
    (sts_wr && sts_word[`ST_MII_ERR]) |-> sts_word[`ST_CRC_ERR];
  endproperty
  a_mii_crc: assert property (p_mii_crc) else $error("crc flag missing on rx error");
  property p_err_sum;
    @(posedge i_clk) disable iff (!i_nrst)
    sts_wr |-> (sts_word[15] == (sts_word[11] | sts_word[7] | sts_word[6] | sts_word[1]));
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("summary error wrong");
  property p_halt_pulse;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_q != rx_pkg::RX_HALTED) ##1 (state_q == rx_pkg::RX_HALTED)
      |-> o_receiver_halted_irq ##1 !o_receiver_halted_irq;
  endproperty
  a_halt_pulse: assert property (p_halt_pulse) else $error("halt pulse wrong");
  property p_stop;
    @(posedge i_clk) disable iff (!i_nrst)
    ((state_q == rx_pkg::RX_IDLE) && !i_receive_enable_bit) |=> o_rx_halted;
  endproperty
  a_stop: assert property (p_stop) else $error("receiver did not halt");
  property p_rxe;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_sts_rd && sts_empty && !flush) |=> o_receiver_error_flag;
  endproperty
  a_rxe: assert property (p_rxe) else $error("underrun not flagged");
  property p_one_word;
    @(posedge i_clk) disable iff (!i_nrst)
    (sts_wr && !flush) |=> (wr_ptr_q == $past(wr_ptr_q) + 1'b1);
  endproperty
  a_one_word: assert property (p_one_word) else $error("status word count wrong");
  c_good_frame: cover property (@(posedge i_clk) disable iff (!i_nrst)
    sts_wr && !sts_word[`ST_ERR_SUM]);
  c_runt_pass: cover property (@(posedge i_clk) disable iff (!i_nrst)
    sts_wr && sts_word[`ST_RUNT]);
  c_halt: cover property (@(posedge i_clk) disable iff (!i_nrst) o_receiver_halted_irq);
  c_overrun: cover property (@(posedge i_clk) disable iff (!i_nrst) overrun);

endmodule

`default_nettype wire

// file: rx_consts.svh
// offsets, field positions and limits of the receive status logic
`ifndef RX_CONSTS_SVH
`define RX_CONSTS_SVH

// ****************************************************************
// frame size limits and header offsets in bytes, minimum type value
// ****************************************************************
`define RX_RUNT_BYTES   14'd64
`define RX_MAX_BYTES    14'd1518
`define RX_WDOG_BYTES   14'd2560
`define RX_HDR_BYTES    14'd14
`define RX_DA_BYTES     14'd6
`define RX_TYPE_HI_IDX  14'd12
`define RX_TYPE_LO_IDX  14'd13
`define RX_TYPE_MIN     16'd1500

// ****************************************************************
// status word field positions
// ****************************************************************
`define ST_LEN_LSB      16
`define ST_LEN_MSB      29
`define ST_ERR_SUM      15
`define ST_BCAST        13
`define ST_RUNT         11
`define ST_MCAST        10
`define ST_TOO_LONG     7
`define ST_LATE_COL     6
`define ST_FTYPE        5
`define ST_WDOG         4
`define ST_MII_ERR      3
`define ST_DRIBBLE      2
`define ST_CRC_ERR      1

// ****************************************************************
// line coding and crc
// ****************************************************************
`define RX_SFD_NIB      4'hd
`define RX_DRIB_10_MIN  3'h3
`define RX_CRC_INIT     32'hffffffff
`define RX_CRC_POLY     32'hedb88320
`define RX_CRC_RESIDUE  32'hdebb20e3

`endif

// file: rx_pkg.sv
// types of the receive status logic
package rx_pkg;

  // ****************************************************************
  // receiver states
  // ****************************************************************
  typedef enum logic [1:0] {
    RX_HALTED   = 2'b00,
    RX_IDLE     = 2'b01,
    RX_PREAMBLE = 2'b10,
    RX_DATA     = 2'b11
  } rx_state_t;

endpackage

// file: rx_status_mem.sv
// storage of the receive status words, registered read data
`timescale 1ns/1ps
`default_nettype none

module rx_status_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // write port
  input  wire logic             i_wr_en,
  input  wire logic [AW-1:0]    i_wr_addr,
  input  wire logic [WIDTH-1:0] i_wr_data,
  // read port
  input  wire logic             i_rd_en,
  input  wire logic [AW-1:0]    i_rd_addr,
  output logic      [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rd_data_q;

  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_data_q <= '0;
    end else if (i_rd_en) begin
      rd_data_q <= mem_q[i_rd_addr];
    end
  end

  assign o_rd_data = rd_data_q;

endmodule

`default_nettype wire

// file: rx_host_model.sv
// host side model that pops receive status words
`timescale 1ns/1ps
`default_nettype none

module rx_host_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // bench controls
  input  wire logic i_hold,
  input  wire logic i_slow,
  input  wire logic i_poke,
  // status fifo
  input  wire logic i_sts_empty,
  output logic      o_sts_rd
);
  // ****************************************
  // one pop at a time, slow mode stalls at random
  // ****************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sts_rd <= 1'h0;
    end else begin
      o_sts_rd <= i_poke || (!o_sts_rd && !i_hold && !i_sts_empty
                  && (!i_slow || $urandom_range(3) == 0));
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench of the receive status word block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int DEPTH = 4;
  logic        i_clk = 1'h0;
  logic        i_nrst = 1'h0;
  logic        mv = 1'h0, dv = 1'h0, er = 1'h0, col = 1'h0, m10 = 1'h0;
  logic        en = 1'h0, pbf = 1'h0, flush = 1'h0, dur = 1'h0, rclr = 1'h0;
  logic        hold = 1'h1, slow = 1'h0, poke = 1'h0;
  logic [3:0]  md = 4'h0;
  logic [2:0]  tail = 3'h0;
  logic [31:0] sdata;
  logic        rd, svalid, sempty, sfull, receiver_error_flag, irq, halted;
  int          errors = 0;
  int          checks = 0;
  int          irqs = 0;
  logic [31:0] exp_q[$];
  logic [7:0]  fr[$];
  int          lens[6] = '{63, 64, 1518, 1519, 2560, 2561};

  always #2.5 i_clk = ~i_clk;

  rx_status_word #(.STS_DEPTH(DEPTH)) rx_status_word_i (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_mii_valid(mv), .i_mii_dv(dv), .i_mii_er(er),
    .i_mii_d(md), .i_mii_col(col), .i_mode_10(m10), .i_tail_bits(tail),
    .i_receive_enable_bit(en), .i_pass_bad_frames(pbf), .i_sts_rd(rd),
    .i_sts_flush(flush), .o_sts_data(sdata), .o_sts_valid(svalid), .o_sts_empty(sempty),
    .o_sts_full(sfull), .i_data_underrun(dur), .i_rxe_clr(rclr),
    .o_receiver_error_flag(receiver_error_flag), .o_receiver_halted_irq(irq), .o_rx_halted(halted));

  rx_host_model rx_host_model_i (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_hold(hold), .i_slow(slow), .i_poke(poke),
    .i_sts_empty(sempty), .o_sts_rd(rd));

  // ****************************************
  // checks and verdict
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run;
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    if (svalid === 1'h1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0, "extra word");
      else chk(sdata, exp_q.pop_front(), "status word");
    end
    if (irq === 1'h1) irqs++;
  end

  // ****************************************
  // frame traffic
  // ****************************************
  task automatic step;
    @(posedge i_clk);
    #1;
  endtask

  task automatic nib(input logic [3:0] d, input logic v);
    mv = 1'h1;
    dv = v;
    md = d;
    step;
  endtask

  function automatic logic [31:0] crc32(input int n);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < n; i++) begin
      c ^= {24'h0, fr[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction

  task automatic mk(input int len);
    fr.delete();
    repeat (len - 4) fr.push_back(8'($urandom));
  endtask

  task automatic send(input int er_at, input int col_at, input bit odd, input bit bad,
                      input bit drop);
    logic [31:0] f;
    logic [31:0] w;
    int          len;
    bit          late;
    bit          bc;
    f = crc32(fr.size()) ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) fr.push_back(f[8*i +: 8]);
    len = fr.size();
    late = col_at >= 128;
    nib(4'h5, 1'h1);
    nib(4'hd, 1'h1);
    for (int n = 0; n < 2 * len + odd; n++) begin
      er = n == er_at;
      col = n == col_at;
      nib(n >= 2 * len ? 4'ha : (n[0] ? fr[n/2][7:4] : fr[n/2][3:0]), 1'h1);
    end
    er = 1'h0;
    col = 1'h0;
    nib(4'h0, 1'h0);
    mv = 1'h0;
    step;
    bc = 1'h1;
    for (int i = 0; i < 6; i++) bc &= fr[i] == 8'hff;
    w = 32'h0;
    w[29:16] = len[13:0];
    w[13] = bc;
    w[11] = len < 64;
    w[10] = fr[0][0];
    w[7] = len > 1518;
    w[6] = late;
    w[5] = (len >= 14) ? ({fr[12], fr[13]} > 16'h5dc) : 1'h0;
    w[4] = len > 2560;
    w[3] = er_at >= 0;
    w[2] = (m10 ? tail >= 3'h3 : odd) && !late;
    w[1] = er_at >= 0 || bad;
    w[15] = w[11] | w[7] | w[6] | w[1];
    if (!drop && !(w[11] && !pbf)) exp_q.push_back(w);
  endtask

  task automatic drain;
    hold = 1'h0;
    for (int i = 0; i < 500 && (exp_q.size() > 0 || sempty !== 1'h1); i++) step;
    chk(exp_q.size(), 0, "drain");
    if (exp_q.size() > 0) complete_run;
    hold = 1'h1;
  endtask

  task automatic clr;
    rclr = 1'h1;
    step;
    rclr = 1'h0;
    step;
    chk(receiver_error_flag, 1'h0, "error clear");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h150c9329));
    repeat (12) @(posedge i_clk);
    #1 i_nrst = 1'h1;
    chk({halted, sempty, sfull, receiver_error_flag, irq, svalid}, 6'h30, "reset");
    en = 1'h1;
    hold = 1'h0;
    step;
    step;
    chk(halted, 1'h0, "enable");
    for (int i = 0; i < 8; i++) begin
      m10 = 1'($urandom);
      tail = 3'($urandom);
      slow = 1'($urandom);
      mk($urandom_range(64, 300));
      send(-1, -1, !m10 && 1'($urandom), 1'h0, 1'h0);
    end
    m10 = 1'h0;
    slow = 1'h0;
    pbf = 1'h1;
    foreach (lens[i]) begin
      mk(lens[i]);
      send(-1, -1, 1'h0, 1'h0, 1'h0);
    end
    mk(10);
    send(-1, -1, 1'h0, 1'h0, 1'h0);
    mk(100);
    send(-1, 150, 1'h1, 1'h0, 1'h0);
    mk(100);
    send(-1, 10, 1'h0, 1'h0, 1'h0);
    mk(80);
    send(30, -1, 1'h0, 1'h0, 1'h0);
    mk(80);
    send(-1, -1, 1'h1, 1'h1, 1'h0);
    mk(70);
    for (int i = 0; i < 6; i++) fr[i] = 8'hff;
    send(-1, -1, 1'h0, 1'h0, 1'h0);
    mk(70);
    fr[12] = 8'h05;
    fr[13] = 8'hdc;
    send(-1, -1, 1'h0, 1'h0, 1'h0);
    m10 = 1'h1;
    for (int t = 2; t < 4; t++) begin
      tail = 3'(t);
      mk(70);
      send(-1, -1, 1'h0, 1'h0, 1'h0);
    end
    m10 = 1'h0;
    drain;
    pbf = 1'h0;
    mk(60);
    send(-1, -1, 1'h0, 1'h0, 1'h0);
    drain;
    repeat (DEPTH) begin
      mk(70);
      send(-1, -1, 1'h0, 1'h0, 1'h0);
    end
    chk(sfull, 1'h1, "full");
    mk(70);
    send(-1, -1, 1'h0, 1'h0, 1'h1);
    chk(receiver_error_flag, 1'h1, "overrun");
    drain;
    mk(70);
    send(-1, -1, 1'h0, 1'h0, 1'h0);
    drain;
    clr;
    poke = 1'h1;
    step;
    poke = 1'h0;
    repeat (3) step;
    chk(receiver_error_flag, 1'h1, "status underrun");
    clr;
    dur = 1'h1;
    step;
    dur = 1'h0;
    step;
    chk(receiver_error_flag, 1'h1, "data underrun");
    clr;
    repeat (2) begin
      mk(70);
      send(-1, -1, 1'h0, 1'h0, 1'h0);
    end
    en = 1'h0;
    for (int i = 0; i < 10 && irq !== 1'h1; i++) step;
    chk({irq, halted}, 2'h3, "halt");
    step;
    chk(irq, 1'h0, "halt pulse");
    mk(70);
    send(-1, -1, 1'h0, 1'h0, 1'h1);
    flush = 1'h1;
    step;
    flush = 1'h0;
    step;
    chk(sempty, 1'h1, "flush");
    exp_q.delete();
    en = 1'h1;
    step;
    step;
    chk(halted, 1'h0, "restart");
    mk(70);
    send(-1, -1, 1'h0, 1'h0, 1'h0);
    drain;
    chk(irqs, 1, "halt pulses");
    complete_run;
  end
endmodule
`default_nettype wire
